// >>> rtl/irq_pkg.sv
// Constants, carrier structs and state types of the interrupt controller.
// Assumes one 200 MHz system clock and an asynchronous active-high reset.
package irq_pkg;

    // ****************************************
    // Bus and register map
    // ****************************************
    localparam int          APB_AW          = 12;
    localparam int          APB_DW          = 32;
    localparam logic [7:0]  IDX_EDGE_HIGH   = 8'hCA;
    localparam logic [7:0]  IDX_EDGE_LOW    = 8'hCB;
    localparam logic [7:0]  IDX_PEND0       = 8'hCC;
    localparam logic [7:0]  IDX_GROUP       = 8'hCD;
    localparam logic [7:0]  IDX_EDGE_PORT1  = 8'hD7;
    localparam logic [7:0]  IDX_PEND1       = 8'hD8;
    localparam logic [7:0]  IDX_TMR_FLAGS   = 8'hEE;
    localparam logic [7:0]  IDX_SRC_EN      = 8'h40;
    localparam logic [7:0]  IDX_CTRL        = 8'h41;
    localparam logic [7:0]  REG_RST         = 8'h00;

    // ****************************************
    // Field positions
    // ****************************************
    localparam logic [1:0]  EDGE_OFF        = 2'h0;
    localparam logic [1:0]  EDGE_FALL       = 2'h1;
    localparam logic [1:0]  EDGE_RISE       = 2'h2;
    localparam logic [1:0]  EDGE_BOTH       = 2'h3;
    localparam int          N_EXT           = 9;
    localparam int          GRP_TOP         = 7;
    localparam int          TF_T0M          = 7;
    localparam int          TF_T2OV         = 2;
    localparam int          SE_BT           = 0;
    localparam int          SE_WDT          = 1;
    localparam int          SE_T2           = 2;
    localparam int          SE_T1           = 3;
    localparam int          SE_T0           = 4;
    localparam int          SE_SIO          = 5;
    localparam int          CTRL_IE         = 0;
    localparam int          CTRL_BRK        = 1;

    // ****************************************
    // Priorities, vectors and acceptance timing
    // ****************************************
    localparam logic [3:0]  PRIO_EXT1       = 4'h1;
    localparam logic [3:0]  PRIO_EXT3       = 4'h2;
    localparam logic [3:0]  PRIO_EXT5       = 4'h3;
    localparam logic [3:0]  PRIO_EXT6       = 4'h4;
    localparam logic [3:0]  PRIO_GROUP      = 4'h5;
    localparam logic [3:0]  PRIO_SIO        = 4'h7;
    localparam logic [3:0]  PRIO_T0         = 4'hA;
    localparam logic [3:0]  PRIO_T1         = 4'hB;
    localparam logic [3:0]  PRIO_T2         = 4'hC;
    localparam logic [3:0]  PRIO_WDT        = 4'hE;
    localparam logic [3:0]  PRIO_BT         = 4'hF;
    localparam logic [15:0] VEC_TOP         = 16'hFFFE;
    localparam logic [15:0] TCALL0_VECTOR   = 16'hFFC0;
    localparam logic [3:0]  ACCEPT_CYCLES   = 4'h8;
    localparam logic [3:0]  PUSH_FIRST      = 4'h1;
    localparam logic [3:0]  PUSH_LAST       = 4'h3;

    typedef enum logic [0:0] {
        ST_IDLE   = 1'b0,
        ST_ACCEPT = 1'b1
    } acc_state_t;

    typedef struct packed {
        logic              psel;
        logic              penable;
        logic              pwrite;
        logic [APB_AW-1:0] paddr;
        logic [APB_DW-1:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic [APB_DW-1:0] prdata;
        logic              pready;
        logic              pslverr;
    } apb_rsp_t;

    typedef struct packed {
        logic instr_done;
        logic software_break_instr;
        logic set_ie;
        logic clr_ie;
    } core_req_t;

    typedef struct packed {
        logic        irq_req;
        logic [15:0] vector;
        logic        sp_dec;
        logic        pc_load;
        logic        psw_brk;
        logic        busy;
        logic        ie;
    } core_rsp_t;

    typedef struct packed {
        logic       bt;
        logic       wdt;
        logic       sio;
        logic [2:0] t_match;
        logic [2:0] t_ovf;
    } src_evt_t;

    // Vector of a priority level: two bytes apart, level 0 at the top
    function automatic logic [15:0] vector_of(input logic [3:0] prio);
        vector_of = VEC_TOP - {11'h000, prio, 1'b0};
    endfunction

endpackage

// >>> rtl/ext_edge_detect.sv
// Synchronises the external pins and flags the selected edges.
// Assumes asynchronous pins and a per-input two-bit edge code.
`timescale 1ns/10ps
module ext_edge_detect #(
    parameter int N = 9
) (
    input  wire logic           clk_sys,
    input  wire logic           sys_rst,
    input  wire logic [N-1:0]   pins,
    input  wire logic [2*N-1:0] edge_cfg,
    output logic      [N-1:0]   edge_hit
);
    typedef struct packed {
        logic [N-1:0] sync1;
        logic [N-1:0] sync2;
        logic [N-1:0] prev;
    } edge_state_t;

    edge_state_t s_q;
    edge_state_t s_d;

    // ****************************************
    // Sampling
    // ****************************************
    always_comb begin
        s_d       = s_q;
        s_d.sync1 = pins;
        s_d.sync2 = s_q.sync1;
        s_d.prev  = s_q.sync2;
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // ****************************************
    // Edge selection
    // ****************************************
    always_comb begin
        for (int i = 0; i < N; i++) begin
            unique case (edge_cfg[2*i +: 2])
                irq_pkg::EDGE_FALL: edge_hit[i] = s_q.prev[i] & ~s_q.sync2[i];
                irq_pkg::EDGE_RISE: edge_hit[i] = ~s_q.prev[i] & s_q.sync2[i];
                irq_pkg::EDGE_BOTH: edge_hit[i] = s_q.prev[i] ^ s_q.sync2[i];
                irq_pkg::EDGE_OFF:  edge_hit[i] = 1'b0;
            endcase
        end
    end
endmodule

// >>> rtl/irq_priority_sel.sv
// Picks the highest-priority pending level out of sixteen.
// Assumes level 0 is reset and never requested here.
`timescale 1ns/10ps
module irq_priority_sel #(
    parameter int LEVELS = 16
) (
    input  wire logic [LEVELS-1:0] req,
    output logic                   valid,
    output logic [3:0]             slot
);
    // Scan from the highest level down so the smallest number wins
    always_comb begin
        valid = 1'b0;
        slot  = 4'h0;
        for (int i = LEVELS - 1; i >= 1; i--) begin
            if (req[i]) begin
                valid = 1'b1;
                slot  = 4'(i);
            end
        end
    end
endmodule

// >>> rtl/irq_ctrl_top.sv
// Interrupt prioritisation, vectoring and external edge interrupts.
// Assumes an APB master, a core that strobes instruction boundaries,
// and same-clock event pulses from the timer, serial and watchdog blocks.
//
// Design decision made here: register access over APB.
`timescale 1ns/10ps
module irq_ctrl_top (
    input  wire logic                  clk_sys,
    input  wire logic                  sys_rst,
    input  wire irq_pkg::apb_req_t     apb_req,
    output irq_pkg::apb_rsp_t          apb_rsp,
    input  wire irq_pkg::core_req_t    core_req,
    output irq_pkg::core_rsp_t         core_rsp,
    input  wire irq_pkg::src_evt_t     src_evt,
    input  wire logic [8:0]            ext_pins
);
    typedef struct packed {
        logic [7:0]           edge_high;
        logic [7:0]           edge_low;
        logic [7:0]           edge_port1;
        logic [8:0]           pending;
        logic [4:0]           group;
        logic [5:0]           tmr_flags;
        logic [5:0]           tmr_req;
        logic                 bt_req;
        logic                 wdt_req;
        logic                 sio_req;
        logic                 brk_req;
        logic [5:0]           src_en;
        logic                 brk_flag;
        irq_pkg::acc_state_t  st;
        logic [3:0]           cnt;
        irq_pkg::apb_rsp_t    apb;
        irq_pkg::core_rsp_t   core;
    } ctl_state_t;

    ctl_state_t s_q;
    ctl_state_t s_d;

    logic [17:0] edge_cfg;
    logic [8:0]  edge_hit;
    logic [8:0]  ext_en;
    logic [4:0]  grp_pend;
    logic [15:0] level_req;
    logic        win_valid;
    logic [3:0]  win_slot;
    logic [7:0]  acc_idx;
    logic        wr_now;
    logic        setup;
    logic [7:0]  rd_val;
    logic        mapped;
    logic [5:0]  tmr_set;
    logic [8:0]  pend_clr;
    logic [5:0]  tmr_clr;

    // ****************************************
    // Edge configuration and pin sampling
    // ****************************************
    // Field order follows input number: 0,1 low; 2..5 high; 6..8 port1
    assign edge_cfg = {s_q.edge_port1[5:0], s_q.edge_high, s_q.edge_low[3:0]};

    always_comb begin
        for (int i = 0; i < irq_pkg::N_EXT; i++) begin
            ext_en[i] = edge_cfg[2*i +: 2] != irq_pkg::EDGE_OFF;
        end
    end

    ext_edge_detect #(
        .N        (irq_pkg::N_EXT)
    ) u_edge (
        .clk_sys  (clk_sys),
        .sys_rst  (sys_rst),
        .pins     (ext_pins),
        .edge_cfg (edge_cfg),
        .edge_hit (edge_hit)
    );

    // Group members in flag-bit order: inputs 0, 2, 4, 7, 8
    assign grp_pend = {s_q.pending[0], s_q.pending[2], s_q.pending[4],
                       s_q.pending[7], s_q.pending[8]}
                    & {ext_en[0], ext_en[2], ext_en[4], ext_en[7], ext_en[8]};

    // Timer flag order: t0 match, t0 ovf, t1 match, t1 ovf, t2 match, t2 ovf
    assign tmr_set = {src_evt.t_match[0], src_evt.t_ovf[0],
                      src_evt.t_match[1], src_evt.t_ovf[1],
                      src_evt.t_match[2], src_evt.t_ovf[2]};

    // ****************************************
    // Priority levels
    // ****************************************
    always_comb begin
        level_req                       = '0;
        level_req[irq_pkg::PRIO_EXT1]   = s_q.pending[1] & ext_en[1];
        level_req[irq_pkg::PRIO_EXT3]   = s_q.pending[3] & ext_en[3];
        level_req[irq_pkg::PRIO_EXT5]   = s_q.pending[5] & ext_en[5];
        level_req[irq_pkg::PRIO_EXT6]   = s_q.pending[6] & ext_en[6];
        level_req[irq_pkg::PRIO_GROUP]  = |grp_pend;
        level_req[irq_pkg::PRIO_SIO]    = s_q.sio_req & s_q.src_en[irq_pkg::SE_SIO];
        level_req[irq_pkg::PRIO_T0]     = |s_q.tmr_req[5:4] & s_q.src_en[irq_pkg::SE_T0];
        level_req[irq_pkg::PRIO_T1]     = |s_q.tmr_req[3:2] & s_q.src_en[irq_pkg::SE_T1];
        level_req[irq_pkg::PRIO_T2]     = |s_q.tmr_req[1:0] & s_q.src_en[irq_pkg::SE_T2];
        level_req[irq_pkg::PRIO_WDT]    = s_q.wdt_req & s_q.src_en[irq_pkg::SE_WDT];
        level_req[irq_pkg::PRIO_BT]     = s_q.bt_req & s_q.src_en[irq_pkg::SE_BT];
        if (!s_q.core.ie) begin
            level_req = '0;
        end
    end

    irq_priority_sel #(
        .LEVELS (16)
    ) u_prio (
        .req    (level_req),
        .valid  (win_valid),
        .slot   (win_slot)
    );

    // ****************************************
    // APB decode
    // ****************************************
    localparam int APB_AW_TOP = irq_pkg::APB_AW - 1;

    assign setup   = apb_req.psel & ~apb_req.penable & ~s_q.apb.pready;
    assign wr_now  = apb_req.psel & apb_req.penable & s_q.apb.pready & apb_req.pwrite;
    assign acc_idx = apb_req.paddr[9:2];

    always_comb begin
        mapped = 1'b1;
        rd_val = 8'h00;
        unique case (acc_idx)
            irq_pkg::IDX_EDGE_HIGH:  rd_val = s_q.edge_high;
            irq_pkg::IDX_EDGE_LOW:   rd_val = {4'h0, s_q.edge_low[3:0]};
            irq_pkg::IDX_PEND0:      rd_val = {2'h0, s_q.pending[5:0]};
            irq_pkg::IDX_GROUP:      rd_val = {s_q.group, 3'h0};
            irq_pkg::IDX_EDGE_PORT1: rd_val = {2'h0, s_q.edge_port1[5:0]};
            irq_pkg::IDX_PEND1:      rd_val = {5'h00, s_q.pending[8:6]};
            irq_pkg::IDX_TMR_FLAGS:  rd_val = {s_q.tmr_flags, 2'h0};
            irq_pkg::IDX_SRC_EN:     rd_val = {2'h0, s_q.src_en};
            irq_pkg::IDX_CTRL:       rd_val = {6'h00, s_q.brk_flag, s_q.core.ie};
            default: begin
                mapped = 1'b0;
                rd_val = 8'h00;
            end
        endcase
        if (apb_req.paddr[1:0] != 2'h0 || apb_req.paddr[APB_AW_TOP:10] != '0) begin
            mapped = 1'b0;
            rd_val = 8'h00;
        end
    end

    // ****************************************
    // Acceptance clears
    // ****************************************
    // The whole shared level is cleared; the flag registers keep the cause
    always_comb begin
        pend_clr = '0;
        tmr_clr  = '0;
        if (s_q.st == irq_pkg::ST_IDLE && core_req.instr_done && win_valid) begin
            unique case (win_slot)
                irq_pkg::PRIO_EXT1:  pend_clr[1] = 1'b1;
                irq_pkg::PRIO_EXT3:  pend_clr[3] = 1'b1;
                irq_pkg::PRIO_EXT5:  pend_clr[5] = 1'b1;
                irq_pkg::PRIO_EXT6:  pend_clr[6] = 1'b1;
                irq_pkg::PRIO_GROUP: pend_clr = 9'h195;
                irq_pkg::PRIO_T0:    tmr_clr  = 6'h30;
                irq_pkg::PRIO_T1:    tmr_clr  = 6'h0C;
                irq_pkg::PRIO_T2:    tmr_clr  = 6'h03;
                default: begin
                    pend_clr = '0;
                    tmr_clr  = '0;
                end
            endcase
        end
    end

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        s_d = s_q;

        // Bus answer: ready one cycle after setup, data latched with it
        s_d.apb.pready  = setup;
        s_d.apb.pslverr = setup & ~mapped;
        s_d.apb.prdata  = (setup && !apb_req.pwrite) ? {24'h000000, rd_val} : '0;

        // Software writes
        if (wr_now && mapped) begin
            unique case (acc_idx)
                irq_pkg::IDX_EDGE_HIGH:  s_d.edge_high  = apb_req.pwdata[7:0];
                irq_pkg::IDX_EDGE_LOW:   s_d.edge_low   = {4'h0, apb_req.pwdata[3:0]};
                irq_pkg::IDX_PEND0:      s_d.pending[5:0] = apb_req.pwdata[5:0];
                irq_pkg::IDX_GROUP:      s_d.group      = apb_req.pwdata[7:3];
                irq_pkg::IDX_EDGE_PORT1: s_d.edge_port1 = {2'h0, apb_req.pwdata[5:0]};
                irq_pkg::IDX_PEND1:      s_d.pending[8:6] = apb_req.pwdata[2:0];
                irq_pkg::IDX_TMR_FLAGS:  s_d.tmr_flags  = apb_req.pwdata[7:2];
                irq_pkg::IDX_SRC_EN:     s_d.src_en     = apb_req.pwdata[5:0];
                irq_pkg::IDX_CTRL: begin
                    s_d.core.ie  = apb_req.pwdata[irq_pkg::CTRL_IE];
                    s_d.brk_flag = s_d.brk_flag & ~apb_req.pwdata[irq_pkg::CTRL_BRK];
                end
                default: s_d.src_en = s_q.src_en;
            endcase
        end

        // Core enable control; software may re-enable for nesting
        if (core_req.set_ie) begin
            s_d.core.ie = 1'b1;
        end
        if (core_req.clr_ie) begin
            s_d.core.ie = 1'b0;
        end

        // Hardware sets win over same-cycle clears, except the SIO, WDT and BT requests cleared at acceptance
        s_d.pending   = (s_d.pending & ~pend_clr) | (edge_hit & ext_en);
        s_d.group     = s_d.group | ({edge_hit[0], edge_hit[2], edge_hit[4],
                                      edge_hit[7], edge_hit[8]}
                                   & {ext_en[0], ext_en[2], ext_en[4],
                                      ext_en[7], ext_en[8]});
        s_d.tmr_flags = s_d.tmr_flags | tmr_set;
        s_d.tmr_req   = (s_q.tmr_req & ~tmr_clr) | tmr_set;
        s_d.sio_req   = src_evt.sio | s_q.sio_req;
        s_d.wdt_req   = src_evt.wdt | s_q.wdt_req;
        s_d.bt_req    = src_evt.bt | s_q.bt_req;
        s_d.brk_req   = core_req.software_break_instr | s_q.brk_req;

        s_d.core.sp_dec  = 1'b0;
        s_d.core.pc_load = 1'b0;
        s_d.core.psw_brk = 1'b0;
        s_d.core.irq_req = win_valid | s_q.brk_req;

        // Acceptance sequence
        unique case (s_q.st)
            irq_pkg::ST_IDLE: begin
                if (core_req.instr_done && (win_valid || s_q.brk_req)) begin
                    s_d.st        = irq_pkg::ST_ACCEPT;
                    s_d.cnt       = 4'h0;
                    s_d.core.busy = 1'b1;
                    s_d.core.ie   = 1'b0;
                    if (win_valid) begin
                        s_d.core.vector = irq_pkg::vector_of(win_slot);
                        s_d.sio_req = s_d.sio_req & ~(win_slot == irq_pkg::PRIO_SIO);
                        s_d.wdt_req = s_d.wdt_req & ~(win_slot == irq_pkg::PRIO_WDT);
                        s_d.bt_req  = s_d.bt_req & ~(win_slot == irq_pkg::PRIO_BT);
                    end else begin
                        // Break ranks below every maskable source
                        s_d.core.vector  = irq_pkg::TCALL0_VECTOR;
                        s_d.core.psw_brk = 1'b1;
                        s_d.brk_flag     = 1'b1;
                        s_d.brk_req      = core_req.software_break_instr;
                    end
                end
            end
            irq_pkg::ST_ACCEPT: begin
                s_d.cnt = s_q.cnt + 4'h1;
                // Return address high, low, then status word
                s_d.core.sp_dec = (s_q.cnt + 4'h1 >= irq_pkg::PUSH_FIRST)
                               && (s_q.cnt + 4'h1 <= irq_pkg::PUSH_LAST);
                if (s_q.cnt == irq_pkg::ACCEPT_CYCLES - 4'h2) begin
                    s_d.core.pc_load = 1'b1;
                end
                if (s_q.cnt == irq_pkg::ACCEPT_CYCLES - 4'h1) begin
                    s_d.st        = irq_pkg::ST_IDLE;
                    s_d.core.busy = 1'b0;
                end
            end
            default: s_d.st = irq_pkg::ST_IDLE;
        endcase
        if (s_q.st == irq_pkg::ST_ACCEPT || s_d.st == irq_pkg::ST_ACCEPT) begin
            s_d.core.irq_req = 1'b0;
        end
    end

    // ****************************************
    // State register
    // ****************************************
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            s_q            <= '0;
            s_q.edge_high  <= irq_pkg::REG_RST;
            s_q.edge_low   <= irq_pkg::REG_RST;
            s_q.edge_port1 <= irq_pkg::REG_RST;
            s_q.st         <= irq_pkg::ST_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    assign apb_rsp  = s_q.apb;
    assign core_rsp = s_q.core;
endmodule

// >>> sim/irq_ctrl_chk.sv
// Port checker of the interrupt controller.
// Assumes it is bound onto irq_ctrl_top.
`timescale 1ns/10ps
module irq_ctrl_chk (
    input wire logic               clk_sys,
    input wire logic               sys_rst,
    input wire irq_pkg::apb_req_t  apb_req,
    input wire irq_pkg::apb_rsp_t  apb_rsp,
    input wire irq_pkg::core_req_t core_req,
    input wire irq_pkg::core_rsp_t core_rsp
);
    // ****
    // Acceptance and bus
    // ****
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    take_busy_a: assert property (core_req.instr_done && core_rsp.irq_req && !core_rsp.busy
        |=> core_rsp.busy && !core_rsp.ie) else $error("acceptance did not start");
    busy_len_a: assert property ($rose(core_rsp.busy)
        |-> core_rsp.busy [*8] ##1 !core_rsp.busy) else $error("busy not eight cycles");
    push_three_a: assert property ($rose(core_rsp.busy)
        |-> ##1 core_rsp.sp_dec [*3] ##1 !core_rsp.sp_dec) else $error("not three pushes");
    vec_load_a: assert property ($rose(core_rsp.busy) |-> ##7 core_rsp.pc_load)
        else $error("vector load late");
    masked_a: assert property ($rose(core_rsp.busy) && !core_rsp.psw_brk |-> $past(core_rsp.ie))
        else $error("taken while masked");
    vec_span_a: assert property ($rose(core_rsp.busy) && !core_rsp.psw_brk
        |-> core_rsp.vector >= 16'hFFE0 && !core_rsp.vector[0]) else $error("bad vector");
    brk_vec_a: assert property ($rose(core_rsp.busy) && core_rsp.psw_brk
        |-> core_rsp.vector == irq_pkg::TCALL0_VECTOR) else $error("bad break vector");
    req_quiet_a: assert property (core_rsp.busy |-> !core_rsp.irq_req)
        else $error("request while accepting");
    apb_ready_a: assert property (apb_req.psel && !apb_req.penable && !apb_rsp.pready
        |=> apb_rsp.pready) else $error("no zero-wait answer");
    cover property ($rose(core_rsp.busy) && core_rsp.psw_brk);
    cover property (core_rsp.pc_load && core_rsp.vector == 16'hFFF4);
    cover property (apb_rsp.pslverr);
endmodule

// >>> sim/core_model.sv
// Core model: strobes instruction ends, forwards commanded enable and break.
// Assumes the bench pulses ei_cmd and brk_cmd for one cycle.
`timescale 1ns/10ps
module core_model (
    input  wire logic               clk_sys,
    input  wire logic               sys_rst,
    input  wire irq_pkg::core_rsp_t core_rsp,
    input  wire logic               ei_cmd,
    input  wire logic               brk_cmd,
    output irq_pkg::core_req_t      core_req
);
    // ****
    // Two-cycle instructions
    // ****
    logic ph_q;
    // No instruction ends during acceptance, as the core is stalled then
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            ph_q     <= 1'b0;
            core_req <= '0;
        end else begin
            ph_q                <= !ph_q;
            core_req.instr_done <= ph_q && !core_rsp.busy;
            core_req.set_ie     <= ei_cmd;
            core_req.software_break_instr        <= brk_cmd;
            core_req.clr_ie     <= 1'b0;
        end
    end
endmodule

// >>> sim/interrupt_priority_and_ext_edge_irq_bench.sv
// Bench: registers, edge modes, group, priorities and break of the controller.
// Assumes the package, design and core model are compiled first.
`timescale 1ns/10ps
module interrupt_priority_and_ext_edge_irq_bench;
    // ****
    // Stimulus and checking
    // ****
    logic               clk_sys    = 1'b0;
    logic               sys_rst    = 1'b1;
    irq_pkg::apb_req_t  req        = '0;
    irq_pkg::apb_rsp_t  rsp;
    irq_pkg::core_req_t creq;
    irq_pkg::core_rsp_t crsp;
    irq_pkg::src_evt_t  evt        = '0;
    logic [8:0]         pins       = 9'h000;
    logic               ei         = 1'b0;
    logic               software_break_instr        = 1'b0;
    logic [8:0]         rd_q[$];
    logic [15:0]        vec_q[$];
    logic [7:0]         ri[3]      = '{8'hCA, 8'hCB, 8'hD7};
    logic [7:0]         msk[3]     = '{8'hFF, 8'h0F, 8'h3F};
    logic [15:0]        pv[6]      = '{16'hFFFC, 16'hFFFA, 16'hFFF6, 16'hFFF0, 16'hFFEA, 16'hFFE0};
    logic [7:0]         r;
    int                 n_mismatch = 0;
    int                 n_tests    = 0;
    int                 cyc        = 0;
    int                 seed       = 32'h01CB;
    always #2.5 clk_sys = !clk_sys;
    irq_ctrl_top i_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .apb_req(req), .apb_rsp(rsp),
        .core_req(creq), .core_rsp(crsp), .src_evt(evt), .ext_pins(pins));
    core_model i_core (.clk_sys(clk_sys), .sys_rst(sys_rst), .core_rsp(crsp), .ei_cmd(ei),
        .brk_cmd(software_break_instr), .core_req(creq));
    task automatic chk(input logic [32:0] e, input logic [32:0] g);
        n_tests++;
        if (g !== e) begin
            n_mismatch++;
            $display("mismatch at %0t: expected %h got %h", $time, e, g);
        end
    endtask
    task automatic give_verdict();
        $display("%0d checks, %0d mismatches", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d,
                       input logic [8:0] e);
        @(posedge clk_sys);
        req <= '{1'b1, 1'b0, w, {2'h0, idx, 2'h0}, {24'h0, d}};
        if (!w)
            rd_q.push_back(e);
        @(posedge clk_sys);
        req.penable <= 1'b1;
        do @(posedge clk_sys); while (rsp.pready !== 1'b1);
        req.psel    <= 1'b0;
        req.penable <= 1'b0;
    endtask
    task automatic accept(input logic b);
        @(posedge clk_sys);
        if (b)
            software_break_instr <= 1'b1;
        else
            ei <= 1'b1;
        @(posedge clk_sys);
        software_break_instr <= 1'b0;
        ei  <= 1'b0;
        do @(posedge clk_sys); while (crsp.pc_load !== 1'b1);
        repeat (3) @(posedge clk_sys);
    endtask
    always @(posedge clk_sys) begin
        if (req.psel && req.penable && rsp.pready === 1'b1 && !req.pwrite) begin
            chk({rd_q[0][8], 24'h0, rd_q[0][7:0]}, {rsp.pslverr, rsp.prdata});
            void'(rd_q.pop_front());
        end
        if (crsp.pc_load === 1'b1)
            chk({17'h0, vec_q.pop_front()}, {17'h0, crsp.vector});
    end
    // Ceiling far above the few hundred cycles the tests need
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            give_verdict();
        end
    end
    initial begin
        repeat (4) @(posedge clk_sys);
        sys_rst <= 1'b0;
        foreach (ri[i]) apb(0, ri[i], 8'h00, 9'h000);
        apb(0, 8'hCD, 8'h00, 9'h000);
        apb(0, 8'h10, 8'h00, 9'h100);
        $display("test reset done");
        foreach (ri[i]) begin
            r = 8'($random(seed)) & msk[i];
            apb(1, ri[i], r, 9'h000);
            apb(0, ri[i], 8'h00, {1'b0, r});
        end
        for (int c = 0; c < 4; c++) begin
            apb(1, 8'hCB, 8'(c << 2), 9'h000);
            apb(1, 8'hCC, 8'h00, 9'h000);
            pins[1] <= 1'b1;
            repeat (6) @(posedge clk_sys);
            apb(0, 8'hCC, 8'h00, {7'h0, c[1], 1'b0});
            apb(1, 8'hCC, 8'h00, 9'h000);
            pins[1] <= 1'b0;
            repeat (6) @(posedge clk_sys);
            apb(0, 8'hCC, 8'h00, {7'h0, c[0], 1'b0});
        end
        $display("test edge modes done");
        apb(1, 8'hCA, 8'hAA, 9'h000);
        apb(1, 8'hCB, 8'h0A, 9'h000);
        apb(1, 8'hD7, 8'h2A, 9'h000);
        apb(1, 8'hCC, 8'h00, 9'h000);
        pins <= 9'h195;
        repeat (6) @(posedge clk_sys);
        apb(0, 8'hCD, 8'h00, 9'h0F8);
        apb(0, 8'hD8, 8'h00, 9'h006);
        apb(0, 8'hCC, 8'h00, 9'h015);
        vec_q.push_back(16'hFFF4);
        accept(1'b0);
        apb(0, 8'hCC, 8'h00, 9'h000);
        apb(0, 8'hD8, 8'h00, 9'h000);
        apb(0, 8'hCD, 8'h00, 9'h0F8);
        apb(1, 8'hCD, 8'h00, 9'h000);
        apb(0, 8'hCD, 8'h00, 9'h000);
        $display("test group done");
        apb(1, 8'h40, 8'h31, 9'h000);
        pins <= 9'h1DF;
        evt  <= '{1'b1, 1'b1, 1'b1, 3'h1, 3'h0};
        @(posedge clk_sys);
        evt <= '0;
        repeat (10) @(posedge clk_sys);
        chk(33'h0, {32'h0, crsp.busy});
        foreach (pv[i]) begin
            vec_q.push_back(pv[i]);
            accept(1'b0);
        end
        apb(0, 8'hEE, 8'h00, 9'h080);
        $display("test priority done");
        vec_q.push_back(irq_pkg::TCALL0_VECTOR);
        accept(1'b1);
        apb(0, 8'h41, 8'h00, 9'h002);
        $display("test break done");
        repeat (4) @(posedge clk_sys);
        give_verdict();
    end
endmodule
bind irq_ctrl_top irq_ctrl_chk i_chk (.clk_sys(clk_sys), .sys_rst(sys_rst), .apb_req(apb_req),
    .apb_rsp(apb_rsp), .core_req(core_req), .core_rsp(core_rsp));
